// *** design/stap_top.sv ***
`timescale 1ns/100ps
module stap_top #(
	parameter logic [31:0] ID_VALUE = 32'h0000_0a5b  // Arbitrary identity value
) (
	// Clock and power-up reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Test clock pin
	input  wire logic        tck,
	input  wire logic        tck_driven,
	// Mode select pin
	input  wire logic        tms,
	input  wire logic        tms_driven,
	// Serial data in pin
	input  wire logic        tdi,
	input  wire logic        tdi_driven,
	// Serial data out pin
	output logic             tdo,
	output logic             tdo_oe,
	// Instruction now in force
	output logic [stap_pkg::IR_WIDTH-1:0] active_instr
);
	import stap_pkg::*;

	// ****************************************************************
	// Pin sampling and controller
	// ****************************************************************
	stap_link_if link ();

	stap_pin_sync u_sync (
		.core_clk   (core_clk),
		.nrst       (nrst),
		.tck        (tck),
		.tck_driven (tck_driven),
		.tms        (tms),
		.tms_driven (tms_driven),
		.tdi        (tdi),
		.tdi_driven (tdi_driven),
		.link       (link)
	);

	stap_tap_fsm u_fsm (
		.core_clk (core_clk),
		.nrst     (nrst),
		.link     (link)
	);

	// ****************************************************************
	// Path decoding
	// ****************************************************************

	// True in any state of the instruction column
	function automatic logic in_ir_column(input stap_state_type st);
		in_ir_column = (st == st_sel_ir) || (st == st_cap_ir) || (st == st_shift_ir)
		            || (st == st_exit1_ir) || (st == st_pause_ir)
		            || (st == st_exit2_ir) || (st == st_upd_ir);
	endfunction : in_ir_column

	// State plus instruction name the register between the pins
	function automatic stap_path_type scan_path(input stap_state_type st,
	                                             input logic [IR_WIDTH-1:0] instr);
		if (in_ir_column(st)) begin
			scan_path = path_ir;
		end else if (instr == INSTR_IDCODE) begin
			scan_path = path_id;
		end else begin
			scan_path = path_bypass;
		end
	endfunction : scan_path

	logic [IR_WIDTH-1:0] ir_shift;
	logic [IR_WIDTH-1:0] ir;
	logic                bypass;
	logic [ID_WIDTH-1:0] id_shift;
	stap_path_type       path;
	logic                do_rise;
	logic                do_fall;
	logic                in_shift;
	logic                next_tdo;

	// Decoded strobes, all on one core clock
	assign path     = scan_path(link.state, ir);   // R7
	assign do_rise  = link.tck_rise;
	assign do_fall  = link.tck_fall;
	assign in_shift = (link.state == st_shift_dr) || (link.state == st_shift_ir);

	// ****************************************************************
	// Instruction register
	// ****************************************************************

	// Shift stage: capture 01 low, shift toward the output end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ir_shift <= IR_RESET;
		end else if (do_rise && link.state == st_cap_ir) begin
			ir_shift <= {IR_CAPTURE_TOP, IR_CAPTURE};       // R16 R2
		end else if (do_rise && link.state == st_shift_ir) begin
			ir_shift <= {link.tdi, ir_shift[IR_WIDTH-1:1]}; // R14 R8
		end
	end

	// Held instruction; takes effect only on update, so a half
	// shifted code never steers the data path
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ir <= IR_RESET;                                 // R15 R12
		end else if (link.state == st_reset) begin
			ir <= IR_RESET;                                 // R15
		end else if (do_fall && link.state == st_upd_ir) begin
			ir <= ir_shift;                                 // R14
		end
	end

	assign active_instr = ir;

	// ****************************************************************
	// Data registers
	// ****************************************************************

	// One-bit bypass: clears on capture, one stage of delay
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			bypass <= BYPASS_CAPTURE;
		end else if (do_rise && link.state == st_cap_dr && path == path_bypass) begin
			bypass <= BYPASS_CAPTURE;                       // R17
		end else if (do_rise && link.state == st_shift_dr && path == path_bypass) begin
			bypass <= link.tdi;                             // R17 R8
		end
	end

	// Identity register: loads the fixed code, bit 0 leaves first
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			id_shift <= '0;
		end else if (do_rise && link.state == st_cap_dr && path == path_id) begin
			id_shift <= ID_VALUE;                           // R7
		end else if (do_rise && link.state == st_shift_dr && path == path_id) begin
			id_shift <= {link.tdi, id_shift[ID_WIDTH-1:1]}; // R8 R2
		end
	end

	// ****************************************************************
	// Serial output
	// ****************************************************************

	// Output end of the chosen register
	always_comb begin
		next_tdo = TDO_RESET;
		unique case (path)
			path_ir:     next_tdo = ir_shift[0];
			path_id:     next_tdo = id_shift[0];
			path_bypass: next_tdo = bypass;
		endcase
	end

	// Pin and its enable move on the falling edge only; the enable
	// stays low from power-up until the clock walks into a shift state
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tdo    <= TDO_RESET;                            // R13
			tdo_oe <= 1'h0;                                 // R13
		end else if (do_fall) begin
			tdo    <= in_shift ? next_tdo : TDO_RESET;      // R3 R8
			tdo_oe <= in_shift;                             // R9 R3
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_shift_id_fall;
		do_fall && link.state == st_shift_dr && path == path_id;
	endsequence

	sequence s_cap_id;
		do_rise && link.state == st_cap_dr && path == path_id;
	endsequence

	sequence s_bypass_shift;
		do_rise && link.state == st_shift_dr && path == path_bypass;
	endsequence

	chk_tdo_on_fall: assert property ($changed(tdo) |-> $past(do_fall)) // R3
		else $error("serial output changed away from a falling edge");

	chk_oe_shift_only: assert property ($rose(tdo_oe) |-> $past(do_fall) // R9
		&& ($past(link.state) == st_shift_dr || $past(link.state) == st_shift_ir))
		else $error("output enabled outside a shift state");

	chk_oe_idle_off: assert property (do_fall && link.state == st_idle |=> !tdo_oe) // R9
		else $error("output still enabled in idle");

	chk_ir_capture: assert property (do_rise && link.state == st_cap_ir // R16
		|=> ir_shift[1:0] == IR_CAPTURE)
		else $error("instruction capture did not load 01");

	chk_ir_default: assert property (link.state == st_reset |=> ir == IR_RESET) // R15
		else $error("reset did not restore identity instruction");

	chk_ir_update: assert property (do_fall && link.state == st_upd_ir // R14
		|=> ir == $past(ir_shift))
		else $error("update did not load shifted instruction");

	chk_ir_rise_only: assert property ($changed(ir_shift) |-> $past(do_rise)) // R2
		else $error("instruction shifter moved off a rising edge");

	chk_bypass_path: assert property (s_bypass_shift |=> bypass == $past(link.tdi)) // R17
		else $error("bypass did not take serial input");

	chk_id_capture: assert property (s_cap_id |=> id_shift == ID_VALUE) // R7
		else $error("identity code not captured");

	chk_id_out: assert property (s_shift_id_fall |=> tdo == $past(id_shift[0]) && tdo_oe) // R8
		else $error("identity tail not on serial output");

	// ****************************************************************
	// Shift path and quiet state checks
	// ****************************************************************

	// One step of each register, named once for the checks below
	sequence s_shift_id_rise;
		do_rise && link.state == st_shift_dr && path == path_id;
	endsequence

	sequence s_shift_ir_rise;
		do_rise && link.state == st_shift_ir;
	endsequence

	sequence s_shift_ir_fall;
		do_fall && link.state == st_shift_ir;
	endsequence

	sequence s_cap_bypass;
		do_rise && link.state == st_cap_dr && path == path_bypass;
	endsequence

	sequence s_bypass_fall;
		do_fall && link.state == st_shift_dr && path == path_bypass;
	endsequence

	sequence s_quiet_fall;
		do_fall && !in_shift;
	endsequence

	// Serial input enters at the head and everything moves one place
	chk_id_shift_in: assert property (s_shift_id_rise // R8
		|=> id_shift == {$past(link.tdi), $past(id_shift[ID_WIDTH-1:1])})
		else $error("identity register did not shift");

	chk_ir_shift_in: assert property (s_shift_ir_rise // R14
		|=> ir_shift == {$past(link.tdi), $past(ir_shift[IR_WIDTH-1:1])})
		else $error("instruction shifter did not shift");

	// The tail reaches the pin on the following fall
	chk_ir_out: assert property (s_shift_ir_fall // R8
		|=> tdo == $past(ir_shift[0]) && tdo_oe)
		else $error("instruction tail not on serial output");

	chk_bypass_out: assert property (s_bypass_fall // R17
		|=> tdo == $past(bypass) && tdo_oe)
		else $error("bypass bit not on serial output");

	chk_bypass_capture: assert property (s_cap_bypass // R17
		|=> bypass == BYPASS_CAPTURE)
		else $error("bypass did not clear on capture");

	// Checked against the held code itself, not the decoded path, so a
	// broken decoder shows up here
	chk_id_select: assert property (do_rise && link.state == st_cap_dr // R7
		&& ir == INSTR_IDCODE |=> id_shift == ID_VALUE)
		else $error("identity code not chosen for its instruction");

	chk_bypass_select: assert property (do_rise && link.state == st_shift_dr // R7
		&& ir != INSTR_IDCODE |=> bypass == $past(link.tdi))
		else $error("bypass not chosen for other instructions");

	// Outside the shift states the pin stays released
	chk_quiet_fall: assert property (s_quiet_fall // R9
		|=> !tdo_oe && tdo == TDO_RESET)
		else $error("serial output driven outside a shift state");

	chk_reset_quiet: assert property (link.state == st_reset // R13
		|| link.state == st_idle |-> !tdo_oe)
		else $error("serial output driven while port is idle");

	// Nothing moves on a core cycle without its test clock edge
	chk_out_hold: assert property (!do_fall // R3
		|=> $stable(tdo) && $stable(tdo_oe))
		else $error("serial output moved without a falling edge");

	chk_id_rise_only: assert property ($changed(id_shift) // R2
		|-> $past(do_rise))
		else $error("identity register moved off a rising edge");

	chk_bypass_rise_only: assert property ($changed(bypass) // R2
		|-> $past(do_rise))
		else $error("bypass moved off a rising edge");

	// Held code changes only on update or in test reset
	chk_ir_hold: assert property (!(do_fall && link.state == st_upd_ir) // R15
		&& link.state != st_reset |=> $stable(ir))
		else $error("held instruction changed outside update");

endmodule : stap_top

// *** shared/stap_pkg.sv ***
// Function
// R1 - Behave as a standard boundary-scan access port
// R2 - Sample all test inputs on rising clock
// R3 - Change serial output only on falling clock
// R4 - Mode select level steers controller each edge
// R5 - Undriven mode select reads as one
// R6 - Undriven serial input shifts in ones
// R7 - State and instruction choose the scan register
// R8 - Input feeds register head, tail drives output
// R9 - Drive serial output only in shift states
// R10 - Five high mode selects force test reset
// R11 - No separate asynchronous test reset input
// R12 - Controller resets itself at power-up
// R13 - Port idle and harmless until clocked
// R14 - Instruction register holds three-bit codes
// R15 - Reset loads identification instruction as default
// R16 - Instruction capture loads 01 into low bits
// R17 - One-bit bypass register shortens scan chain
// R18 - Leave reset on low select, sixteen-state diagram
package stap_pkg;

	// ****************************************************************
	// Widths and codes
	// ****************************************************************
	localparam int unsigned IR_WIDTH   = 3;
	localparam int unsigned ID_WIDTH   = 32;
	localparam logic [2:0]  INSTR_EXTEST   = 3'h0;
	localparam logic [2:0]  INSTR_IDCODE   = 3'h1;
	localparam logic [2:0]  INSTR_SAMPLE_Z = 3'h2;
	localparam logic [2:0]  INSTR_SAMPLE   = 3'h4;
	localparam logic [2:0]  INSTR_BYPASS   = 3'h7;
	localparam logic [1:0]  IR_CAPTURE     = 2'h1;
	localparam logic        IR_CAPTURE_TOP = 1'h0;

	// ****************************************************************
	// Values after reset and counts
	// ****************************************************************
	localparam logic [2:0]  IR_RESET       = INSTR_IDCODE;
	localparam logic [2:0]  SYNC_RESET     = 3'h7;
	localparam logic [2:0]  TLR_ONES       = 3'h5;
	localparam logic        TDO_RESET      = 1'h0;
	localparam logic        BYPASS_CAPTURE = 1'h0;

	// ****************************************************************
	// Controller states, one-hot
	// ****************************************************************
	typedef enum logic [15:0] {
		st_reset    = 16'h0001,
		st_idle     = 16'h0002,
		st_sel_dr   = 16'h0004,
		st_cap_dr   = 16'h0008,
		st_shift_dr = 16'h0010,
		st_exit1_dr = 16'h0020,
		st_pause_dr = 16'h0040,
		st_exit2_dr = 16'h0080,
		st_upd_dr   = 16'h0100,
		st_sel_ir   = 16'h0200,
		st_cap_ir   = 16'h0400,
		st_shift_ir = 16'h0800,
		st_exit1_ir = 16'h1000,
		st_pause_ir = 16'h2000,
		st_exit2_ir = 16'h4000,
		st_upd_ir   = 16'h8000
	} stap_state_type;

	// Register placed between serial input and output
	typedef enum logic [2:0] {
		path_ir     = 3'h1,
		path_bypass = 3'h2,
		path_id     = 3'h4
	} stap_path_type;

endpackage : stap_pkg

// *** shared/stap_link_if.sv ***
`timescale 1ns/100ps
interface stap_link_if;
	logic                    tck_rise;
	logic                    tck_fall;
	logic                    tms;
	logic                    tdi;
	stap_pkg::stap_state_type state;

	modport sync_mp (output tck_rise, output tck_fall, output tms, output tdi);
	modport fsm_mp  (input tck_rise, input tms, output state);
	modport core_mp (input tck_rise, input tck_fall, input tms, input tdi, input state);
endinterface : stap_link_if

// *** design/stap_pin_sync.sv ***
`timescale 1ns/100ps
module stap_pin_sync (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Test pins with their drive flags
	input  wire logic        tck,
	input  wire logic        tck_driven,
	input  wire logic        tms,
	input  wire logic        tms_driven,
	input  wire logic        tdi,
	input  wire logic        tdi_driven,
	// Sampled view
	stap_link_if.sync_mp     link
);
	import stap_pkg::*;

	logic [2:0] pad_lvl;
	logic [2:0] sync1;
	logic [2:0] sync2;
	logic       tck_prev;

	// Pull-ups: a floating pin reads high
	assign pad_lvl = {tck_driven ? tck : 1'h1,
	                  tms_driven ? tms : 1'h1,    // R5
	                  tdi_driven ? tdi : 1'h1};   // R6

	// Two flops before anything reads the pins
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sync1 <= SYNC_RESET;
			sync2 <= SYNC_RESET;
		end else begin
			sync1 <= pad_lvl;
			sync2 <= sync1;
		end
	end

	// Edge finder on the settled clock; resets high so no false rising edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tck_prev <= SYNC_RESET[2];
		end else begin
			tck_prev <= sync2[2];
		end
	end

	assign link.tck_rise = sync2[2] & ~tck_prev;
	assign link.tck_fall = ~sync2[2] & tck_prev;
	assign link.tms      = sync2[1];
	assign link.tdi      = sync2[0];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_float_high: assert property ((!tms_driven && !tdi_driven) [*3] // R5 R6
		|-> link.tms && link.tdi)
		else $error("floating select or data did not read high");

endmodule : stap_pin_sync

// *** design/stap_tap_fsm.sv ***
`timescale 1ns/100ps
module stap_tap_fsm (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Sampled pins in, state out
	stap_link_if.fsm_mp      link
);
	import stap_pkg::*;

	stap_state_type state;
	logic [2:0]     ones_cnt;

	// Sixteen-state diagram, steered only by the select level
	function automatic stap_state_type next_state(input stap_state_type st, input logic sel);
		unique case (st)
			st_reset:    next_state = sel ? st_reset    : st_idle;
			st_idle:     next_state = sel ? st_sel_dr   : st_idle;
			st_sel_dr:   next_state = sel ? st_sel_ir   : st_cap_dr;
			st_cap_dr:   next_state = sel ? st_exit1_dr : st_shift_dr;
			st_shift_dr: next_state = sel ? st_exit1_dr : st_shift_dr;
			st_exit1_dr: next_state = sel ? st_upd_dr   : st_pause_dr;
			st_pause_dr: next_state = sel ? st_exit2_dr : st_pause_dr;
			st_exit2_dr: next_state = sel ? st_upd_dr   : st_shift_dr;
			st_upd_dr:   next_state = sel ? st_sel_dr   : st_idle;
			st_sel_ir:   next_state = sel ? st_reset    : st_cap_ir;
			st_cap_ir:   next_state = sel ? st_exit1_ir : st_shift_ir;
			st_shift_ir: next_state = sel ? st_exit1_ir : st_shift_ir;
			st_exit1_ir: next_state = sel ? st_upd_ir   : st_pause_ir;
			st_pause_ir: next_state = sel ? st_exit2_ir : st_pause_ir;
			st_exit2_ir: next_state = sel ? st_upd_ir   : st_shift_ir;
			st_upd_ir:   next_state = sel ? st_sel_dr   : st_idle;
			default:     next_state = st_reset;
		endcase
	endfunction : next_state

	// Power-up reset is the only asynchronous path; no test reset pin
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= st_reset;                             // R12 R11
		end else if (link.tck_rise) begin
			state <= next_state(state, link.tms);          // R4 R18 R10 R1
		end
	end

	assign link.state = state;

	// Helper: run of high selects seen on rising edges
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ones_cnt <= 3'h0;
		end else if (link.tck_rise) begin
			ones_cnt <= !link.tms ? 3'h0 : (ones_cnt == TLR_ONES) ? ones_cnt : ones_cnt + 3'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	chk_five_ones: assert property ((ones_cnt == TLR_ONES) |-> (state == st_reset)) // R10
		else $error("five high selects did not reach test reset");
	chk_reset_exit: assert property (link.tck_rise && !link.tms && state == st_reset // R18
		|=> state == st_idle)
		else $error("reset state not left on low select");
	chk_state_hold: assert property (!link.tck_rise |=> $stable(state)) // R4
		else $error("state moved without a rising test clock");

endmodule : stap_tap_fsm

// *** test/stap_ctrl_model.sv ***
`timescale 1ns/100ps
// ****
// Board test controller model
// ****
module stap_ctrl_model (
	// Clock
	input  wire logic core_clk,
	// Pins towards the port
	output logic      tck,
	output logic      tck_driven,
	output logic      tms,
	output logic      tms_driven,
	output logic      tdi,
	output logic      tdi_driven,
	input  wire logic tdo,
	input  wire logic tdo_oe
);
	// Released pins toggle, so only the drive flag may make them read high
	initial begin
		tck        = 1'h0;
		tck_driven = 1'h0;
		tms        = 1'h0;
		tms_driven = 1'h0;
		tdi        = 1'h0;
		tdi_driven = 1'h0;
	end

	// One 80 ns period, tck low outside it; inputs set 20 ns before the rise
	task automatic cycle(input logic t, input logic d, input logic [2:0] drv,
		output logic [1:0] late, output logic [1:0] fall);
		tck_driven <= drv[2];
		tms_driven <= drv[1];
		tdi_driven <= drv[0];
		tms        <= drv[1] ? t : ~tms;
		tdi        <= drv[0] ? d : ~tdi;
		repeat (5) @(negedge core_clk);
		tck <= 1'h1;
		repeat (9) @(negedge core_clk);
		late = {tdo_oe, tdo};
		@(negedge core_clk);
		tck <= 1'h0;
		repeat (5) @(negedge core_clk);
		fall = {tdo_oe, tdo};
	endtask : cycle
endmodule : stap_ctrl_model

// *** test/stap_top_tb_top.sv ***
`timescale 1ns/100ps
module stap_top_tb_top;
	import stap_pkg::*;

	// ****
	// Design, partner and clock
	// ****
	localparam logic [31:0] ID_VAL = 32'h0c3a_5e17; // Arbitrary identity value
	logic           core_clk;
	logic           nrst;
	logic           tck;
	logic           tck_driven;
	logic           tms;
	logic           tms_driven;
	logic           tdi;
	logic           tdi_driven;
	logic           tdo;
	logic           tdo_oe;
	logic [2:0]     active_instr;
	int             fail_count = 0;
	int             check_count = 0;
	logic [31:0]    rng = 32'h4f;
	// Reference model state
	stap_state_type m_state;
	logic [2:0]     m_ir;
	logic [2:0]     m_irs;
	logic [31:0]    m_sr;
	int             m_len;
	logic [1:0]     m_out;

	initial core_clk = 1'h0;
	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	stap_top #(.ID_VALUE(ID_VAL)) uut (
		.core_clk(core_clk), .nrst(nrst), .tck(tck), .tck_driven(tck_driven),
		.tms(tms), .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven),
		.tdo(tdo), .tdo_oe(tdo_oe), .active_instr(active_instr));

	stap_ctrl_model ctrl (
		.core_clk(core_clk), .tck(tck), .tck_driven(tck_driven),
		.tms(tms), .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven),
		.tdo(tdo), .tdo_oe(tdo_oe));

	// ****
	// Reference model and helpers
	// ****
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction : rnd

	function automatic stap_state_type nxt(input stap_state_type s, input logic t);
		case (s)
			st_reset:    return t ? st_reset : st_idle;
			st_idle:     return t ? st_sel_dr : st_idle;
			st_sel_dr:   return t ? st_sel_ir : st_cap_dr;
			st_cap_dr:   return t ? st_exit1_dr : st_shift_dr;
			st_shift_dr: return t ? st_exit1_dr : st_shift_dr;
			st_exit1_dr: return t ? st_upd_dr : st_pause_dr;
			st_pause_dr: return t ? st_exit2_dr : st_pause_dr;
			st_exit2_dr: return t ? st_upd_dr : st_shift_dr;
			st_upd_dr:   return t ? st_sel_dr : st_idle;
			st_sel_ir:   return t ? st_reset : st_cap_ir;
			st_cap_ir:   return t ? st_exit1_ir : st_shift_ir;
			st_shift_ir: return t ? st_exit1_ir : st_shift_ir;
			st_exit1_ir: return t ? st_upd_ir : st_pause_ir;
			st_pause_ir: return t ? st_exit2_ir : st_pause_ir;
			st_exit2_ir: return t ? st_upd_ir : st_shift_ir;
			default:     return t ? st_sel_dr : st_idle;
		endcase
	endfunction : nxt

	task automatic model_reset();
		m_state = st_reset;
		m_ir    = INSTR_IDCODE;
		m_irs   = INSTR_IDCODE;
		m_sr    = 32'h0;
		m_len   = 1;
		m_out   = 2'h0;
	endtask : model_reset

	// Rising edge work, then what the following fall shows
	task automatic model_step(input logic t, input logic d);
		case (m_state)
			st_cap_dr: begin
				m_len = (m_ir === INSTR_IDCODE) ? 32 : 1;
				m_sr  = (m_len == 32) ? ID_VAL : 32'h0;
			end
			st_shift_dr: m_sr = (m_len == 32) ? {d, m_sr[31:1]} : {31'h0, d};
			st_cap_ir:   m_irs = 3'h1;
			st_shift_ir: m_irs = {d, m_irs[2:1]};
			default:     ;
		endcase
		m_state = nxt(m_state, t);
		if (m_state == st_upd_ir)
			m_ir = m_irs;
		if (m_state == st_reset)
			m_ir = INSTR_IDCODE;
		m_out[1] = (m_state == st_shift_dr) || (m_state == st_shift_ir);
		m_out[0] = !m_out[1] ? 1'h0 : (m_state == st_shift_dr) ? m_sr[0] : m_irs[0];
	endtask : model_step

	task automatic cmp_out(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t oe_tdo got %h exp %h", $time, got, exp);
		end
	endtask : cmp_out

	task automatic cmp_instr(input logic [2:0] got, input logic [2:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t instr got %h exp %h", $time, got, exp);
		end
	endtask : cmp_instr

	// One test clock period; a released tck gives the model no edge
	task automatic tick(input logic t, input logic d, input logic [2:0] drv);
		logic [1:0] late;
		logic [1:0] fall;
		ctrl.cycle(t, d, drv, late, fall);
		cmp_out(late, m_out);
		if (drv[2])
			model_step(drv[1] ? t : 1'h1, drv[0] ? d : 1'h1);
		cmp_out(fall, m_out);
		cmp_instr(active_instr, m_ir);
	endtask : tick

	task automatic go(input logic [63:0] t, input logic [63:0] d, input int n);
		for (int i = 0; i < n; i++)
			tick(t[i], d[i], 3'h7);
	endtask : go

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	// ****
	// Tests
	// ****
	initial begin
		logic [31:0] r;
		nrst = 1'h0;
		model_reset();
		repeat (12) @(negedge core_clk);
		cmp_out({tdo_oe, tdo}, 2'h0);
		cmp_instr(active_instr, INSTR_IDCODE);
		nrst = 1'h1;
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < 4; i++)
			tick(i == 1, 1'h0, 3'h3);
		$display("test floating clock done");
		go(64'h1f, 64'h0, 5);
		go(64'h0000_0018_0000_0002, {rnd(), rnd()}, 38);
		$display("test identity read done");
		for (int c = 0; c < 8; c++) begin
			go(64'hc3, 64'(c) << 4, 9);
			cmp_instr(active_instr, 3'(c));
			go(64'h3501, {rnd(), rnd()}, 15);
		end
		$display("test instruction codes done");
		for (int i = 0; i < 400; i++) begin
			r = rnd();
			tick(r[0], r[1], {1'h1, r[3:2]});
		end
		$display("test random walk done");
		go(64'h1f, 64'h0, 6);
		go(64'hc3, 64'h70, 9);
		go(64'h2, 64'h0, 4);
		repeat (5) tick(1'h0, 1'h0, 3'h5);
		cmp_instr(active_instr, INSTR_IDCODE);
		$display("test floating select reset done");
		go(64'h2, 64'h0, 4);
		nrst = 1'h0;
		repeat (3) @(negedge core_clk);
		model_reset();
		cmp_out({tdo_oe, tdo}, 2'h0);
		nrst = 1'h1;
		repeat (4) @(negedge core_clk);
		go(64'h0000_0018_0000_0002, {rnd(), rnd()}, 38);
		$display("test mid-run reset done");
		report_and_stop();
	end

	// Watchdog: about 705 test clock periods of 80 ns expected, allow over three times that
	initial begin
		#200000;
		fail_count++;
		report_and_stop();
	end
endmodule : stap_top_tb_top
